// file: common/power_readback_pkg.sv
package power_readback_pkg;
  localparam int ADDR_W = 7;
  localparam int DATA_W = 9;
  localparam logic [6:0] ADDR_POWER_ONE = 7'h32;
  localparam logic [6:0] ADDR_POWER_TWO = 7'h33;
  localparam logic [6:0] ADDR_READBACK = 7'h34;
  localparam logic [6:0] ADDR_SOFT_RESET = 7'h35;
  localparam logic [8:0] POWER_ONE_RESET = 9'h07e;
  localparam logic [8:0] POWER_TWO_RESET = 9'h03e;
  localparam logic [8:0] READBACK_RESET = 9'h000;
  localparam logic [8:0] POWER_ONE_MASK = 9'h07f;
  localparam logic [8:0] POWER_TWO_MASK = 9'h03f;
  localparam logic [8:0] READBACK_MASK = 9'h01f;
  localparam int BIT_CHIP_SAVE = 0;
  localparam int BIT_ADC_OFF = 1;
  localparam int BIT_DAC_LO = 2;
  localparam int BIT_ALL_DACS = 6;
  localparam int BIT_OSC_OFF = 0;
  localparam int BIT_PLL1_OFF = 1;
  localparam int BIT_PLL2_OFF = 2;
  localparam int BIT_RECOVERY_OFF = 3;
  localparam int BIT_TX_OFF = 4;
  localparam int BIT_RX_OFF = 5;
  localparam int BIT_CONT_READ = 3;
  localparam int BIT_READ_EN = 4;
  localparam int STAT_NONPCM = 0;
  localparam int STAT_RATE_LO = 4;
  localparam int STAT_UNLOCK = 6;
  localparam logic [2:0] SEL_ERROR = 3'h0;
  localparam logic [2:0] SEL_CHAN1 = 3'h1;
  localparam logic [2:0] SEL_CHAN2 = 3'h2;
  localparam logic [2:0] SEL_CHAN3 = 3'h3;
  localparam logic [2:0] SEL_CHAN4 = 3'h4;
  localparam logic [2:0] SEL_CHAN5 = 3'h5;
  localparam logic [2:0] SEL_RXSTAT = 3'h6;
endpackage

// file: logic/power_readback_reset_regs.sv
`timescale 1ns/10ps
`default_nettype none
module power_readback_reset_regs
  import power_readback_pkg::*;
(
  // Clock and reset
  input wire logic sysClk,
  input wire logic rst,
  // Register write port from the serial control decoder
  input wire logic wrEn,
  input wire logic [ADDR_W-1:0] wrAddr,
  input wire logic [DATA_W-1:0] wrData,
  // Register read port
  input wire logic [ADDR_W-1:0] rdAddr,
  output logic [DATA_W-1:0] rdData,
  // Status from the receiver
  input wire logic [1:0] recoveredRateCode,
  input wire logic recoveryUnlocked,
  input wire logic nonPcmBit,
  input wire logic [7:0] rxStatusUpper,
  input wire logic [7:0] errorStatus,
  input wire logic [7:0] chanStatus1,
  input wire logic [7:0] chanStatus2,
  input wire logic [7:0] chanStatus3,
  input wire logic [7:0] chanStatus4,
  input wire logic [7:0] chanStatus5,
  // Power controls to sub-blocks
  output logic digitalSave,
  output logic outputsMuted,
  output logic adcOff,
  output logic [3:0] dacOff,
  output logic oscillatorOff,
  output logic firstPllOff,
  output logic secondPllOff,
  output logic clockRecoveryOff,
  output logic transmitterOff,
  output logic receiverOff,
  // Read-back path
  output logic readbackActive,
  output logic continuousReadback,
  output logic [2:0] statusSelect,
  output logic [7:0] readbackData
);

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  logic [8:0] powerOne_r;
  logic [8:0] powerTwo_r;
  logic [8:0] readback_r;
  logic [1:0] rateSync1_r, rateSync2_r;
  logic unlockSync1_r, unlockSync2_r;
  logic pcmSync1_r, pcmSync2_r;

  wire wrPowerOne = wrEn && (wrAddr == ADDR_POWER_ONE);
  wire wrPowerTwo = wrEn && (wrAddr == ADDR_POWER_TWO);
  wire wrReadback = wrEn && (wrAddr == ADDR_READBACK);
  wire softReset = wrEn && (wrAddr == ADDR_SOFT_RESET);

  always_ff @(posedge sysClk) begin
    if (rst || softReset) begin
      powerOne_r <= POWER_ONE_RESET;
      powerTwo_r <= POWER_TWO_RESET;
      readback_r <= READBACK_RESET;
    end else begin
      if (wrPowerOne) begin
        powerOne_r <= wrData & POWER_ONE_MASK;
      end
      if (wrPowerTwo) begin
        powerTwo_r <= wrData & POWER_TWO_MASK;
      end
      if (wrReadback) begin
        readback_r <= wrData & READBACK_MASK;
      end
    end
  end

  // ---------------------------------------------------------------
  // Status synchronisers
  // ---------------------------------------------------------------
  always_ff @(posedge sysClk) begin
    if (rst) begin
      rateSync1_r <= 2'h0;
      rateSync2_r <= 2'h0;
      unlockSync1_r <= 1'b1;
      unlockSync2_r <= 1'b1;
      pcmSync1_r <= 1'b0;
      pcmSync2_r <= 1'b0;
    end else begin
      rateSync1_r <= recoveredRateCode;
      rateSync2_r <= rateSync1_r;
      unlockSync1_r <= recoveryUnlocked;
      unlockSync2_r <= unlockSync1_r;
      pcmSync1_r <= nonPcmBit;
      pcmSync2_r <= pcmSync1_r;
    end
  end

  // ---------------------------------------------------------------
  // Decode
  // ---------------------------------------------------------------
  wire chipSave = powerOne_r[BIT_CHIP_SAVE];
  wire allDacs = powerOne_r[BIT_ALL_DACS];
  wire [3:0] dacBits = powerOne_r[BIT_DAC_LO +: 4];
  wire [3:0] dacOffNxt = {4{allDacs || chipSave}} | dacBits;
  wire adcOffNxt = chipSave || powerOne_r[BIT_ADC_OFF];
  wire oscOffNxt = chipSave || powerTwo_r[BIT_OSC_OFF];
  wire pll1OffNxt = chipSave || powerTwo_r[BIT_PLL1_OFF];
  wire pll2OffNxt = chipSave || powerTwo_r[BIT_PLL2_OFF];
  wire recOffNxt = chipSave || powerTwo_r[BIT_RECOVERY_OFF];
  wire txOffNxt = chipSave || powerTwo_r[BIT_TX_OFF];
  wire rxOffNxt = chipSave || powerTwo_r[BIT_RX_OFF];

  wire [7:0] rxStatusWord;
  assign rxStatusWord = {rxStatusUpper[7], unlockSync2_r, rateSync2_r,
                         rxStatusUpper[3:1], pcmSync2_r};

  wire [2:0] selNxt = readback_r[2:0];
  wire readEnNxt = readback_r[BIT_READ_EN];
  logic [7:0] selectedWord;
  always_comb begin
    case (selNxt)
      SEL_ERROR: selectedWord = errorStatus;
      SEL_CHAN1: selectedWord = chanStatus1;
      SEL_CHAN2: selectedWord = chanStatus2;
      SEL_CHAN3: selectedWord = chanStatus3;
      SEL_CHAN4: selectedWord = chanStatus4;
      SEL_CHAN5: selectedWord = chanStatus5;
      SEL_RXSTAT: selectedWord = rxStatusWord;
      default: selectedWord = 8'h00;
    endcase
  end

  logic [8:0] rdNxt;
  always_comb begin
    case (rdAddr)
      ADDR_POWER_ONE: rdNxt = powerOne_r;
      ADDR_POWER_TWO: rdNxt = powerTwo_r;
      ADDR_READBACK: rdNxt = readback_r;
      default: rdNxt = 9'h000;
    endcase
  end

  // ---------------------------------------------------------------
  // Registered outputs
  // ---------------------------------------------------------------
  always_ff @(posedge sysClk) begin
    if (rst) begin
      rdData <= 9'h000;
      digitalSave <= 1'b0;
      outputsMuted <= 1'b0;
      adcOff <= 1'b1;
      dacOff <= 4'hf;
      oscillatorOff <= 1'b0;
      firstPllOff <= 1'b1;
      secondPllOff <= 1'b1;
      clockRecoveryOff <= 1'b1;
      transmitterOff <= 1'b1;
      receiverOff <= 1'b1;
      readbackActive <= 1'b0;
      continuousReadback <= 1'b0;
      statusSelect <= 3'h0;
      readbackData <= 8'h00;
    end else begin
      rdData <= rdNxt;
      digitalSave <= chipSave;
      outputsMuted <= chipSave;
      adcOff <= adcOffNxt;
      dacOff <= dacOffNxt;
      oscillatorOff <= oscOffNxt;
      firstPllOff <= pll1OffNxt;
      secondPllOff <= pll2OffNxt;
      clockRecoveryOff <= recOffNxt;
      transmitterOff <= txOffNxt;
      receiverOff <= rxOffNxt;
      readbackActive <= readEnNxt;
      continuousReadback <= readEnNxt && readback_r[BIT_CONT_READ];
      statusSelect <= selNxt;
      readbackData <= readEnNxt ? selectedWord : 8'h00;
    end
  end

endmodule
`default_nettype wire

// file: verification/power_readback_asserts.sv
`timescale 1ns/10ps
`default_nettype none
module power_readback_asserts
  import power_readback_pkg::*;
(
  // Watched ports
  input wire logic sysClk, rst, wrEn,
  input wire logic [ADDR_W-1:0] wrAddr,
  input wire logic [DATA_W-1:0] wrData,
  input wire logic [7:0] errorStatus, chanStatus5, readbackData,
  input wire logic digitalSave, outputsMuted, adcOff, oscillatorOff,
  input wire logic firstPllOff, secondPllOff, clockRecoveryOff,
  input wire logic transmitterOff, receiverOff,
  input wire logic readbackActive, continuousReadback,
  input wire logic [3:0] dacOff,
  input wire logic [2:0] statusSelect
);
  default clocking @(posedge sysClk); endclocking
  default disable iff (rst);
  logic [8:0] d1, d2;
  wire logic w1 = wrEn && wrAddr == ADDR_POWER_ONE;
  wire logic w2 = wrEn && wrAddr == ADDR_POWER_TWO;
  wire logic w3 = wrEn && wrAddr == ADDR_READBACK;
  wire logic w5 = wrEn && wrAddr == ADDR_SOFT_RESET;
  wire logic [5:0] pw2 = {receiverOff, transmitterOff, clockRecoveryOff,
    secondPllOff, firstPllOff, oscillatorOff};
  // Write data two cycles back
  always_ff @(posedge sysClk) begin
    d1 <= wrData;
    d2 <= d1;
  end
  a_save_mute: assert property (digitalSave == outputsMuted)
    else $error("mute differs from save");
  a_save_all_off: assert property (digitalSave |-> adcOff && &dacOff && &pw2)
    else $error("block on during save");
  a_dac_write: assert property (w1 |-> ##2 dacOff == (d2[5:2] | {4{d2[6] | d2[0]}}))
    else $error("dac off wrong");
  a_adc_write: assert property (w1 |-> ##2 adcOff == (d2[1] | d2[0]) && digitalSave == d2[0])
    else $error("adc off wrong");
  a_pw2_write: assert property (w2 |-> ##2 pw2 == (d2[5:0] | {6{digitalSave}}))
    else $error("second power bits wrong");
  a_rb_write: assert property (w3 |-> ##2 statusSelect == d2[2:0] && readbackActive == d2[4] && continuousReadback == (d2[4] & d2[3]))
    else $error("readback control wrong");
  a_soft_reset: assert property (w5 |-> ##2 adcOff && &dacOff && !oscillatorOff && !digitalSave && !readbackActive && statusSelect == SEL_ERROR)
    else $error("soft reset missed");
  a_rb_idle: assert property (!readbackActive |-> readbackData == 8'h00)
    else $error("readback data while off");
  a_err_pick: assert property (readbackActive && statusSelect == SEL_ERROR |-> readbackData == $past(errorStatus))
    else $error("error word wrong");
  a_chan_pick: assert property (readbackActive && statusSelect == SEL_CHAN5 |-> readbackData == $past(chanStatus5))
    else $error("channel word wrong");
  c_soft: cover property (w5);
  c_rx: cover property (readbackActive && statusSelect == SEL_RXSTAT);
  c_cont: cover property (continuousReadback);
endmodule
bind power_readback_reset_regs power_readback_asserts i_power_readback_asserts (.*);
`default_nettype wire

// file: verification/power_readback_reset_regs_tb.sv
`timescale 1ns/10ps
`default_nettype none
module power_readback_reset_regs_tb;
  import power_readback_pkg::*;
  logic sysClk = 0, rst = 1, wrEn = 0, recoveryUnlocked = 0, nonPcmBit = 0;
  logic [6:0] wrAddr = 0, rdAddr = 0;
  logic [8:0] wrData = 0, rdData, p1 = 9'h07e, p2 = 9'h03e, rb = 9'h000;
  logic [1:0] recoveredRateCode = 0;
  logic [7:0] rxStatusUpper = 0, errorStatus = 0, chanStatus1 = 0;
  logic [7:0] chanStatus2 = 0, chanStatus3 = 0, chanStatus4 = 0;
  logic [7:0] chanStatus5 = 0, readbackData, ws [8];
  logic digitalSave, outputsMuted, adcOff, oscillatorOff, firstPllOff;
  logic secondPllOff, clockRecoveryOff, transmitterOff, receiverOff;
  logic readbackActive, continuousReadback;
  logic [3:0] dacOff;
  logic [2:0] statusSelect;
  int n_errors = 0, checks = 0;
  power_readback_reset_regs i_power_readback_reset_regs (.*);
  initial forever #4 sysClk = ~sysClk;
  // ----------------
  // Checks and steps
  // ----------------
  task automatic chk(string nm, logic [8:0] e, logic [8:0] g);
    checks++;
    if (g !== e) begin
      $display("BAD %s exp %h got %h", nm, e, g);
      n_errors++;
    end
  endtask
  task automatic tally_and_finish;
    if (n_errors == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic rd(logic [6:0] a, logic [8:0] e);
    @(posedge sysClk);
    rdAddr <= a;
    @(posedge sysClk);
    #1 chk("rdData", e, rdData);
  endtask
  task automatic step(logic [6:0] a, logic [8:0] d);
    logic s;
    {errorStatus, chanStatus1, chanStatus2, chanStatus3, chanStatus4,
      chanStatus5, rxStatusUpper, recoveredRateCode, recoveryUnlocked,
      nonPcmBit} <= 60'({$urandom, $urandom});
    @(posedge sysClk);
    wrEn <= 1;
    wrAddr <= a;
    wrData <= d;
    @(posedge sysClk);
    wrEn <= 0;
    if (a == ADDR_POWER_ONE) p1 = d & 9'h07f;
    if (a == ADDR_POWER_TWO) p2 = d & 9'h03f;
    if (a == ADDR_READBACK) rb = d & 9'h01f;
    if (a == ADDR_SOFT_RESET) {p1, p2, rb} = {9'h07e, 9'h03e, 9'h000};
    rd(ADDR_POWER_ONE, p1);
    rd(ADDR_POWER_TWO, p2);
    rd(ADDR_READBACK, rb);
    rd(ADDR_SOFT_RESET, 9'h000);
    rd(7'h00, 9'h000);
    s = p1[0];
    chk("save", {7'h0, s, s}, {7'h0, digitalSave, outputsMuted});
    chk("adcDac", {4'h0, p1[5:2] | {4{p1[6] | s}}, p1[1] | s},
      {4'h0, dacOff, adcOff});
    chk("pw2", {3'h0, p2[5:0] | {6{s}}}, {3'h0, receiverOff, transmitterOff,
      clockRecoveryOff, secondPllOff, firstPllOff, oscillatorOff});
    chk("rbCtl", {4'h0, rb[2:0], rb[4], rb[4] & rb[3]}, {4'h0, statusSelect,
      readbackActive, continuousReadback});
    ws = '{errorStatus, chanStatus1, chanStatus2, chanStatus3, chanStatus4,
      chanStatus5, {rxStatusUpper[7], recoveryUnlocked, recoveredRateCode,
      rxStatusUpper[3:1], nonPcmBit}, 8'h00};
    chk("readback", {1'b0, rb[4] ? ws[rb[2:0]] : 8'h00},
      {1'b0, readbackData});
  endtask
  initial begin
    repeat (20000) @(posedge sysClk);
    n_errors++;
    tally_and_finish;
  end
  initial begin
    void'($urandom(32'h85cb));
    repeat (12) @(posedge sysClk);
    rst <= 0;
    step(7'h01, 9'h1ff);
    step(ADDR_POWER_TWO, 9'h000);
    step(ADDR_POWER_ONE, 9'h001);
    step(ADDR_POWER_ONE, 9'h1ff);
    for (int i = 0; i < 8; i++) step(ADDR_READBACK, 9'h1f8 | 9'(i));
    for (int i = 0; i < 60; i++)
      step(ADDR_POWER_ONE + 7'($urandom_range(3)), 9'($urandom));
    tally_and_finish;
  end
endmodule
`default_nettype wire
